// File: rtl/fcmp_top.sv
// Digital control and output conditioning for four fast analog comparators.
`timescale 1ns/1ps
module fcmp_top
    import fcmp_pkg::*;
#(
    parameter int N = NUM_CMP
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Raw analog comparator results, asynchronous to clk_i.
    input wire logic [N-1:0] raw_compare_i,
    // PWM clock as a one-cycle enable pulse in the clk_i domain.
    input wire logic pwm_clk_en_i,
    // Low-power mode indications.
    input wire logic sleep_i,
    input wire logic idle_i,
    // Analog configuration per comparator.
    output fcmp_analog_cfg_t [N-1:0] analog_cfg_o,
    // Conditioned outputs per comparator.
    output fcmp_fanout_t [N-1:0] fanout_o,
    // Wake request from any enabled comparator.
    output logic wake_o
);

    // Parameter check: the map holds exactly four comparators.
    if (N != NUM_CMP) begin : g_bad_n
        $error("fcmp_top supports exactly four comparators.");
    end

    // Software-visible registers.
    logic [15:0] ctrl_q [N];
    logic [CODE_W-1:0] code_q [N];
    // Conditioned output per comparator, after filter or bypass.
    logic [N-1:0] cond_q;
    // Polarity-corrected synchronised level used for the state bit.
    logic [N-1:0] pol_state;
    // Bus decode helpers.
    logic bus_req;
    logic [1:0] sel_idx;
    logic is_ctrl;
    logic is_code;
    logic in_map;
    logic [31:0] rd_d;

    // Decode: a request is active while cyc and stb are high and no ack or err is out.
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign in_map = (wb_adr_i < MAP_END) && (wb_adr_i[1:0] == 2'h0);
    assign sel_idx = wb_adr_i[4:3];
    assign is_ctrl = in_map && (wb_adr_i[2] == CTRL_BASE[2]);
    assign is_code = in_map && (wb_adr_i[2] == CODE_BASE[2]);

    // Answer every request one cycle after it is seen; unmapped gets err.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req && in_map;
            wb_err_o <= bus_req && !in_map;
        end
    end

    // Read data mux; reserved bits read as zero.
    always_comb begin
        rd_d = 32'h0000_0000;
        if (is_ctrl) begin
            rd_d[15:0] = ctrl_q[sel_idx] & CTRL_WMASK;
            rd_d[B_STATE] = pol_state[sel_idx];
        end else if (is_code) begin
            rd_d[CODE_W-1:0] = code_q[sel_idx];
        end
    end

    // Read data register, loaded alongside ack.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i && in_map) begin
            wb_dat_o <= rd_d;
        end
    end

    // Register writes with byte lanes, taken when the request is seen.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < N; i++) begin
                ctrl_q[i] <= CTRL_RESET;
                code_q[i] <= CODE_RESET;
            end
        end else if (bus_req && wb_we_i) begin
            if (is_ctrl) begin
                if (wb_sel_i[0]) begin
                    ctrl_q[sel_idx][7:0] <= wb_dat_i[7:0] & CTRL_WMASK[7:0];
                end
                if (wb_sel_i[1]) begin
                    ctrl_q[sel_idx][15:8] <= wb_dat_i[15:8] & CTRL_WMASK[15:8];
                end
            end else if (is_code) begin
                if (wb_sel_i[0]) begin
                    code_q[sel_idx][7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    code_q[sel_idx][CODE_W-1:8] <= wb_dat_i[CODE_W-1:8];
                end
            end
        end
    end

    // Per-comparator conditioning chain.
    for (genvar g = 0; g < N; g++) begin : g_cmp
        // Three-stage synchroniser for the asynchronous raw result.
        logic [2:0] sync_q;
        // Stretcher hold counter and output.
        logic [1:0] hold_q;
        logic stretch_q;
        // Filter run counter.
        logic [1:0] run_q;
        logic filt_q;
        // Derived controls.
        logic inv;
        logic alt;
        logic [1:0] insel;
        logic fclk;
        logic tick;
        logic pol_in;
        logic pol_prev;
        logic rise;

        assign inv = ctrl_q[g][B_INV];
        assign alt = ctrl_q[g][B_ALT];
        assign insel = ctrl_q[g][B_INSEL_LO +: 2];
        assign fclk = ctrl_q[g][B_FCLK];
        // Selected clock: PWM enable pulse or every system cycle.
        assign tick = fclk ? pwm_clk_en_i : 1'b1;

        // Synchroniser; the first stage feeds only the second.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                sync_q <= 3'h0;
            end else begin
                sync_q <= {sync_q[1], sync_q[0], raw_compare_i[g]};
            end
        end

        // Polarity applied to agreed samples before the stretcher.
        assign pol_in = (sync_q[1] & sync_q[2]) ^ inv;
        assign pol_prev = sync_q[2] ^ inv;
        assign rise = pol_in && !pol_prev;
        assign pol_state[g] = sync_q[2] ^ inv;

        // Stretcher: set at once by the event, held at least three cycles.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                hold_q <= 2'h0;
                stretch_q <= 1'b0;
            end else if (pol_in) begin
                stretch_q <= 1'b1;
                hold_q <= 2'(STRETCH_LEN - 1);
            end else if (hold_q != 2'h0) begin
                if (tick) begin
                    hold_q <= hold_q - 2'h1;
                end
            end else if (tick) begin
                stretch_q <= 1'b0;
            end
        end

        // Filter: new level passes after three equal selected-clock samples.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                run_q <= 2'h0;
                filt_q <= 1'b0;
            end else if (tick) begin
                if (stretch_q == filt_q) begin
                    run_q <= 2'h0;
                end else if (run_q == 2'(FILT_LEN - 1)) begin
                    filt_q <= stretch_q;
                    run_q <= 2'h0;
                end else begin
                    run_q <= run_q + 2'h1;
                end
            end
        end

        // Output select: zero while disabled, filter when enabled, else stretcher or event straight.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cond_q[g] <= 1'b0;
            end else if (!ctrl_q[g][B_ENABLE]) begin
                cond_q[g] <= 1'b0;
            end else if (ctrl_q[g][B_FILT_EN]) begin
                cond_q[g] <= filt_q;
            end else begin
                cond_q[g] <= stretch_q | pol_in;
            end
        end

        // Fan-out to all consumers at once.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                fanout_o[g] <= '0;
            end else begin
                fanout_o[g] <= {5{cond_q[g]}};
            end
        end

        // Analog configuration from control and threshold registers.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                analog_cfg_o[g] <= '{1'b0, FCMP_SRC_NONE, FCMP_REF_OFF, CODE_RESET,
                                     2'h0, 1'b0, 1'b0};
            end else begin
                analog_cfg_o[g].powered <= ctrl_q[g][B_ENABLE];
                // Inverting input is hard-wired to this threshold code.
                analog_cfg_o[g].threshold_code <= code_q[g];
                if (alt) begin
                    unique case (insel)
                        2'h0: analog_cfg_o[g].source <= FCMP_SRC_AMP_1;
                        2'h1: analog_cfg_o[g].source <= FCMP_SRC_AMP_2;
                        default: analog_cfg_o[g].source <= FCMP_SRC_NONE;
                    endcase
                end else begin
                    analog_cfg_o[g].source <= fcmp_src_t'({1'b0, insel});
                end
                if (ctrl_q[g][B_EXTERNAL_REFERENCE_SELECT]) begin
                    analog_cfg_o[g].reference <= FCMP_REF_EXTERNAL;
                end else if (ctrl_q[g][B_RANGE]) begin
                    analog_cfg_o[g].reference <= FCMP_REF_SUPPLY;
                end else begin
                    analog_cfg_o[g].reference <= FCMP_REF_OFF;
                end
                analog_cfg_o[g].hysteresis_amount <= ctrl_q[g][B_HYS_LO +: 2];
                // One selects the falling edge, zero the rising edge.
                analog_cfg_o[g].hysteresis_edge_select <= ctrl_q[g][B_HYS_EDGE];
                // Several set at once leaves the pin undefined.
                analog_cfg_o[g].reference_pin_output_enable <= ctrl_q[g][B_REFPIN];
            end
        end

        // Unused helper kept out of logic.
        logic unused_rise;
        assign unused_rise = rise;
    end

    // Wake request while sleeping or idle on any enabled output event.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= (sleep_i || idle_i) && (|cond_q);
        end
    end

endmodule : fcmp_top

// File: rtl/fcmp_pkg.sv
// Package with register map, field positions and shared types for the comparator logic.
package fcmp_pkg;

    // Number of comparators in the block.
    localparam int NUM_CMP = 4;
    // Width of the threshold code.
    localparam int CODE_W = 12;
    // Samples of equal level needed by the glitch filter.
    localparam int FILT_LEN = 3;
    // Least stretched pulse width in system clock cycles.
    localparam int STRETCH_LEN = 3;

    // Byte offsets: control register n at CTRL_BASE + 8n, threshold at CODE_BASE + 8n.
    localparam logic [7:0] CTRL_BASE = 8'h00;
    localparam logic [7:0] CODE_BASE = 8'h04;
    localparam logic [7:0] CMP_STRIDE = 8'h08;
    localparam logic [7:0] MAP_END = 8'h20;

    // Control register field positions.
    localparam int B_ENABLE = 15;
    localparam int B_HYS_LO = 11;
    localparam int B_FILT_EN = 10;
    localparam int B_FCLK = 9;
    localparam int B_REFPIN = 8;
    localparam int B_INSEL_LO = 6;
    localparam int B_EXTERNAL_REFERENCE_SELECT = 5;
    localparam int B_HYS_EDGE = 4;
    localparam int B_STATE = 3;
    localparam int B_ALT = 2;
    localparam int B_INV = 1;
    localparam int B_RANGE = 0;

    // Writable bits of the control register; state bit and bit 14 read only.
    localparam logic [15:0] CTRL_WMASK = 16'hBFF7;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [11:0] CODE_RESET = 12'h000;

    // Analog source selection handed to the analog side.
    typedef enum logic [2:0] {
        FCMP_SRC_PIN_A,
        FCMP_SRC_PIN_B,
        FCMP_SRC_PIN_C,
        FCMP_SRC_PIN_D,
        FCMP_SRC_AMP_1,
        FCMP_SRC_AMP_2,
        FCMP_SRC_NONE
    } fcmp_src_t;

    // Reference selection handed to the threshold converter.
    typedef enum logic [1:0] {
        FCMP_REF_EXTERNAL,
        FCMP_REF_SUPPLY,
        FCMP_REF_OFF
    } fcmp_ref_t;

    // Analog configuration of one comparator.
    typedef struct packed {
        logic powered;
        fcmp_src_t source;
        fcmp_ref_t reference;
        logic [CODE_W-1:0] threshold_code;
        logic [1:0] hysteresis_amount;
        logic hysteresis_edge_select;
        logic reference_pin_output_enable;
    } fcmp_analog_cfg_t;

    // Conditioned output fan-out of one comparator.
    typedef struct packed {
        logic irq_event;
        logic adc_trigger;
        logic pwm_pulse_trunc;
        logic pwm_period_trunc;
        logic pwm_fault;
    } fcmp_fanout_t;

endpackage : fcmp_pkg

// File: tb/fcmp_pwm_model.sv
// Model of the PWM side: clock enable ticks and a count of fault events.
`timescale 1ns/1ps
module fcmp_pwm_model
    import fcmp_pkg::*;
#(
    parameter int DIV = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fault_i,
    output logic pwm_clk_en_o,
    output logic [7:0] fault_count_o
);
    // Tick divider and last fault level.
    logic [3:0] div_q;
    logic fault_q;
    // One PWM tick every DIV system cycles.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 4'h0;
            pwm_clk_en_o <= 1'b0;
        end else begin
            div_q <= (div_q == 4'(DIV - 1)) ? 4'h0 : div_q + 4'h1;
            pwm_clk_en_o <= (div_q == 4'(DIV - 1));
        end
    end
    // The fault latch counts each new event once.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_q <= 1'b0;
            fault_count_o <= 8'h00;
        end else begin
            fault_q <= fault_i;
            fault_count_o <= fault_count_o + 8'(fault_i & !fault_q);
        end
    end
endmodule : fcmp_pwm_model

// File: tb/fcmp_top_sva.sv
// Checker for bus answers and output shaping of the comparator block.
`timescale 1ns/1ps
module fcmp_top_sva
    import fcmp_pkg::*;
#(
    parameter int N = NUM_CMP
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire fcmp_fanout_t [N-1:0] fanout_o
);
    // High while every comparator gives one level to all consumers.
    logic fan_ok;
    // A request that still waits for its answer.
    logic req;
    assign req = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
    always_comb begin
        fan_ok = 1'b1;
        for (int k = 0; k < N; k++) begin
            fan_ok &= (&fanout_o[k]) | ~(|fanout_o[k]);
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    answer_next_a: assert property (req |=> wb_ack_o | wb_err_o) else $error("no answer");
    map_err_a: assert property (req && wb_adr_i >= MAP_END |=> wb_err_o && !wb_ack_o)
        else $error("unmapped not refused");
    align_err_a: assert property (req && wb_adr_i[1:0] != 2'b00 |=> wb_err_o)
        else $error("unaligned not refused");
    no_spurious_a: assert property ((wb_ack_o | wb_err_o) |-> $past(req))
        else $error("answer without request");
    one_answer_a: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
    data_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("data moved");
    fan_equal_a: assert property (fan_ok) else $error("consumers disagree");
    stretch_min_a: assert property ($rose(fanout_o[0].irq_event) |->
        fanout_o[0].irq_event [*3]) else $error("pulse too short");
endmodule : fcmp_top_sva
bind fcmp_top fcmp_top_sva #(.N(N)) i_fcmp_top_sva (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .fanout_o(fanout_o));

// File: tb/fcmp_top_test.sv
// Self-checking bench for the comparator output logic.
`timescale 1ns/1ps
module fcmp_top_test;
    import fcmp_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack, err, pwm_en, sleep, idle, wake;
    logic [7:0] adr, faults;
    logic [31:0] wdat, rdat;
    logic [3:0] raw;
    fcmp_analog_cfg_t [3:0] cfg;
    fcmp_fanout_t [3:0] fan;
    int n_mismatch = 0;
    int n_tests = 0;
    fcmp_top i_fcmp_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .raw_compare_i(raw), .pwm_clk_en_i(pwm_en),
        .sleep_i(sleep), .idle_i(idle), .analog_cfg_o(cfg), .fanout_o(fan), .wake_o(wake));
    fcmp_pwm_model i_fcmp_pwm_model (.clk_i(clk_i), .rst_i(rst_i),
        .fault_i(fan[0].pwm_fault), .pwm_clk_en_o(pwm_en), .fault_count_o(faults));
    // Free-running system clock.
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Counts a comparison and reports a mismatch.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    // One classic bus cycle; answer sampled and request released at the same rising edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack !== 1'b1 && err !== 1'b1 && i < 20);
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (i >= 20) begin
            n_mismatch++;
            stop_test();
        end
    endtask : bus
    // Register contents, analog settings and refused accesses.
    task automatic t_regs();
        logic [31:0] q;
        logic e;
        logic [15:0] c;
        fcmp_src_t s;
        bus(1'b1, CTRL_BASE, 32'h0000_FFFF, q, e);
        bus(1'b1, CODE_BASE, 32'h0000_FFFF, q, e);
        bus(1'b0, CTRL_BASE, 32'h0, q, e);
        check("ctrl", q[15:0], 16'hBFFF);
        bus(1'b0, CODE_BASE, 32'h0, q, e);
        check("code", q[11:0], 12'hFFF);
        check("thr", cfg[0].threshold_code, 12'hFFF);
        check("pin", cfg[0].reference_pin_output_enable, 1'b1);
        check("ext", cfg[0].reference, FCMP_REF_EXTERNAL);
        check("powered", cfg[0].powered, 1'b1);
        for (int i = 0; i < 8; i++) begin
            c = 16'h8000 | (16'(i[1:0]) << 11) | (16'(i[1:0]) << 6) | (16'(i[2]) << 2);
            c = c | (16'(i[0]) << 4) | 16'(i[0]);
            s = i[2] ? (i[0] ? FCMP_SRC_AMP_2 : FCMP_SRC_AMP_1) : fcmp_src_t'(3'(i[1:0]));
            bus(1'b1, CTRL_BASE, {16'h0000, c}, q, e);
            @(negedge clk_i);
            if (i < 6) check("src", cfg[0].source, s);
            check("hys", cfg[0].hysteresis_amount, i[1:0]);
            check("edge", cfg[0].hysteresis_edge_select, i[0]);
            check("ref", cfg[0].reference, i[0] ? FCMP_REF_SUPPLY : FCMP_REF_OFF);
        end
        bus(1'b1, CTRL_BASE, 32'h0000_8000, q, e);
        bus(1'b1, CTRL_BASE + 8'h01, 32'h0000_FFFF, q, e);
        check("unaligned", e, 1'b1);
        bus(1'b1, MAP_END, 32'h0000_FFFF, q, e);
        check("unmapped", e, 1'b1);
        bus(1'b0, CTRL_BASE, 32'h0, q, e);
        check("kept", q[15:0], 16'h8000);
    endtask : t_regs
    // Delay from a raw rise on comparator 0 to its consumers.
    task automatic lat(input logic [15:0] c, output int n);
        logic [31:0] q;
        logic e;
        bus(1'b1, CTRL_BASE, {16'h0000, c}, q, e);
        repeat (20) @(posedge clk_i);
        raw[0] <= 1'b1;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (fan[0].irq_event !== 1'b1 && n < 60);
        if (n >= 60) begin
            n_mismatch++;
            stop_test();
        end
        @(posedge clk_i);
        raw[0] <= 1'b0;
        repeat (40) @(posedge clk_i);
    endtask : lat
    // Filter off, on with the system clock, on with the PWM clock.
    task automatic t_filter();
        int a, b, c;
        lat(16'h8000, a);
        lat(16'h8400, b);
        lat(16'h8600, c);
        check("direct", a <= 8, 1'b1);
        check("filtered", b >= a + 2, 1'b1);
        check("pwm clock", c >= b + 4, 1'b1);
    endtask : t_filter
    // Narrow event, wake-up, fault count and polarity.
    task automatic t_stretch();
        logic [31:0] q;
        logic e, woke;
        logic [7:0] f0;
        int hi;
        bus(1'b1, CTRL_BASE, 32'h0000_8000, q, e);
        sleep <= 1'b1;
        f0 = faults;
        woke = 1'b0;
        hi = 0;
        raw[0] <= 1'b1;
        repeat (2) @(posedge clk_i);
        raw[0] <= 1'b0;
        repeat (30) begin
            @(negedge clk_i);
            hi += (fan[0].irq_event === 1'b1);
            woke |= (wake === 1'b1);
        end
        check("stretch", hi >= 3, 1'b1);
        check("wake", woke, 1'b1);
        check("faults", faults - f0, 8'h01);
        sleep <= 1'b0;
        idle <= 1'b1;
        bus(1'b1, CTRL_BASE, 32'h0000_8002, q, e);
        repeat (10) @(negedge clk_i);
        check("invert", fan[0].irq_event, 1'b1);
        check("idle wake", wake, 1'b1);
        bus(1'b0, CTRL_BASE, 32'h0, q, e);
        check("state", q[B_STATE], 1'b1);
    endtask : t_stretch
    // Reset, then the scenarios in turn.
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, sleep, idle} = 5'h00;
        adr = 8'h00;
        wdat = 32'h0;
        raw = 4'h0;
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        check("rst src", cfg[0].source, FCMP_SRC_NONE);
        check("rst ref", cfg[0].reference, FCMP_REF_OFF);
        @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_filter();
        t_stretch();
        stop_test();
    end
endmodule : fcmp_top_test
